// File: standby_pkg.sv
package standby_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] WDOG_OFS      = 8'h04;
   localparam logic [7:0] STAT_OFS      = 8'h08;
   localparam logic [7:0] WAKE_OFS      = 8'h0C;
   localparam logic [7:0] PRE12_OFS     = 8'h10;
   localparam logic [7:0] TMR1_OFS      = 8'h14;
   // Control and watchdog kick fields
   localparam int CTRL_STOP_BIT   = 0;
   localparam int CTRL_STAB_BIT   = 1;
   localparam int CTRL_SDIS_BIT   = 2;
   localparam int CTRL_WSEL_BIT   = 3;
   localparam int CTRL_TXY_BIT    = 4;
   localparam int CTRL_SER_BIT    = 5;
   localparam int WDOG_KICK6_BIT  = 6;
   localparam int WDOG_KICK7_BIT  = 7;
   // Reset values and auto preloads
   localparam logic [7:0] PRE12_AUTO   = 8'hFF;
   localparam logic [7:0] TMR1_AUTO    = 8'h01;
   localparam logic [7:0] WDL_RESET    = 8'hFF;
   localparam logic [7:0] WDH_RESET    = 8'hFF;
   localparam logic [5:0] CTRL_RESET   = 6'h00;
   localparam logic [7:0] WAKE_RESET   = 8'h00;
   // Reset pin timing in main oscillator cycles
   localparam int RST_ENTER_CYC   = 20;
   localparam int RST_LEAVE_CYC   = 14;
   localparam int OSC_DIV         = 2;
endpackage

// File: sync_pulse.sv
`timescale 1ns/1ps
// Two-flop synchroniser with rising-edge pulse on the settled copy
module sync_pulse #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] lvl_o,
   output logic      [W-1:0] rise_o
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // ==========================================
   // Synchroniser chain; s1 is read only by s2
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign lvl_o  = s2_reg;
   assign rise_o = s2_reg & ~s3_reg;
endmodule

// File: stop_mode_standby_control.sv
`timescale 1ns/1ps
module stop_mode_standby_control (
   input  wire logic        REF_CLK_I,
   input  wire logic        RESETN_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HSEL_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   input  wire logic        STOP_INSTRUCTION_I,
   input  wire logic        RESET_PIN_N_I,
   input  wire logic [3:0]  EXTERNAL_IRQ_PINS_I,
   input  wire logic        COUNTER_PIN_ZERO_I,
   input  wire logic        COUNTER_PIN_ONE_I,
   input  wire logic        SERIAL_IRQ_I,
   input  wire logic        TIMER_XY_IRQ_I,
   output logic             MAIN_OSC_RUN_O,
   output logic             SUB_OSC_RUN_O,
   output logic             CPU_CLK_EN_O,
   output logic             PERIPH_RUN_O,
   output logic             TIMER_XY_RUN_O,
   output logic             SERIAL_RUN_O,
   output logic             PORT_HOLD_O,
   output logic             PORT_INPUT_O,
   output logic             CORE_RESET_N_O,
   output logic             STOPPED_O
);
   // ==========================================
   // States
   typedef enum logic [3:0] {
      RUN_S    = 4'b0001,
      STOP_S   = 4'b0010,
      STAB_S   = 4'b0100,
      RESET_S  = 4'b1000
   } state_type;

   state_type   state_reg, state_next;
   logic [5:0]  ctrl_reg;
   logic [7:0]  wake_en_reg;
   logic [7:0]  pre12_reg;
   logic [7:0]  pre12_ld_reg;
   logic [7:0]  tmr1_reg;
   logic [7:0]  wdl_reg;
   logic [7:0]  wdh_reg;
   logic [4:0]  rst_cnt_reg;
   logic        in_reset_reg;
   logic [3:0]  rel_cnt_reg;
   logic        div_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [31:0] rdata_reg;
   logic        wdh_uf_reg;

   // ==========================================
   // Pin synchronisers for reset pin and wake sources
   logic [7:0] pins_lvl;
   logic [7:0] pins_rise;
   sync_pulse #(.W(8)) u_sync (
      .clk_i  (REF_CLK_I),
      .rstn_i (RESETN_I),
      .d_i    ({TIMER_XY_IRQ_I, SERIAL_IRQ_I, COUNTER_PIN_ONE_I,
                COUNTER_PIN_ZERO_I, EXTERNAL_IRQ_PINS_I}),
      .lvl_o  (pins_lvl),
      .rise_o (pins_rise)
   );
   logic rst_s1_reg;
   logic rst_pin_low_reg;
   // Reset pin: first stage idles high, so no false low after reset
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         rst_s1_reg      <= 1'b1;
         rst_pin_low_reg <= 1'b0;
      end else begin
         rst_s1_reg      <= RESET_PIN_N_I;
         rst_pin_low_reg <= ~rst_s1_reg;
      end
   end

   // ==========================================
   // Main oscillator cycle enable: one pulse per OSC_DIV clocks
   wire osc_tick = div_reg;
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) div_reg <= 1'b0;
      else div_reg <= ~div_reg;
   end

   // ==========================================
   // Bus decode
   wire       addr_ph   = HSEL_I & HREADY_I & HTRANS_I[1];
   wire [7:0] rd_ofs    = HADDR_I[7:0];
   wire       wr_ctrl   = wr_pend_reg & (wr_addr_reg == standby_pkg::CTRL_OFS);
   wire       wr_wdog   = wr_pend_reg & (wr_addr_reg == standby_pkg::WDOG_OFS);
   wire       wr_wake   = wr_pend_reg & (wr_addr_reg == standby_pkg::WAKE_OFS);
   wire       wr_pre    = wr_pend_reg & (wr_addr_reg == standby_pkg::PRE12_OFS);
   wire       wr_tmr    = wr_pend_reg & (wr_addr_reg == standby_pkg::TMR1_OFS);
   wire       stab_sel  = ctrl_reg[standby_pkg::CTRL_STAB_BIT];
   wire       stop_dis  = ctrl_reg[standby_pkg::CTRL_SDIS_BIT];
   wire [31:0] rd_mux =
      (rd_ofs == standby_pkg::CTRL_OFS)  ? {26'h000_0000, ctrl_reg} :
      (rd_ofs == standby_pkg::WDOG_OFS)  ? {16'h0000, wdh_reg, wdl_reg} :
      (rd_ofs == standby_pkg::STAT_OFS)  ? {24'h00_0000, pins_lvl[3:0],
                                            state_reg} :
      (rd_ofs == standby_pkg::WAKE_OFS)  ? {24'h00_0000, wake_en_reg} :
      (rd_ofs == standby_pkg::PRE12_OFS) ? {24'h00_0000, pre12_reg} :
      (rd_ofs == standby_pkg::TMR1_OFS)  ? {24'h00_0000, tmr1_reg} :
      32'h0000_0000;

   // Zero-wait slave: registered write address, bus write data applied in the data phase
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg   <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= addr_ph & HWRITE_I;
         wr_addr_reg <= rd_ofs;
         if (addr_ph & ~HWRITE_I) rdata_reg <= rd_mux;
      end
   end

   // ==========================================
   // Wake decode: only the listed sources, gated by software enables
   // Serial and timer X/Y requests count only in their external modes
   // Enables are armed by software before the stop
   wire [7:0] wake_ok  = {ctrl_reg[standby_pkg::CTRL_TXY_BIT],
                          ctrl_reg[standby_pkg::CTRL_SER_BIT], 6'h3F};
   wire       wake_req = |(pins_rise & wake_en_reg & wake_ok);
   wire stop_cmd = STOP_INSTRUCTION_I & ~stop_dis;

   // ==========================================
   // Standby sequencer
   wire t1_uf = (state_reg == STAB_S) & osc_tick &
                (pre12_reg == 8'h00) & (tmr1_reg == 8'h00);
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         RUN_S:   if (stop_cmd) state_next = STOP_S;
         STOP_S:  if (wake_req) state_next = STAB_S;
         STAB_S:  if (t1_uf) state_next = RUN_S;
         RESET_S: state_next = RESET_S;
         default: state_next = RUN_S;
      endcase
      if (in_reset_reg) state_next = RESET_S;
      else if (state_reg == RESET_S) state_next = RUN_S;
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) state_reg <= RESET_S;
      else state_reg <= state_next;
   end

   // ==========================================
   // Reset pin filter: 20 cycles to enter, about 14 to leave
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         rst_cnt_reg  <= 5'd0;
         rel_cnt_reg  <= 4'd0;
         in_reset_reg <= 1'b1;
      end else begin
         // Any high sample restarts the low run, even between ticks,
         // so a short release cannot shorten the next reset request
         if (!rst_pin_low_reg) rst_cnt_reg <= 5'd0;
         else if (osc_tick &&
                  rst_cnt_reg != 5'(standby_pkg::RST_ENTER_CYC))
            rst_cnt_reg <= rst_cnt_reg + 5'd1;
         if (osc_tick) begin
            if (rst_pin_low_reg &&
                rst_cnt_reg == 5'(standby_pkg::RST_ENTER_CYC - 1)) begin
               in_reset_reg <= 1'b1;
               rel_cnt_reg  <= 4'd0;
            end else if (in_reset_reg && !rst_pin_low_reg) begin
               if (rel_cnt_reg == 4'(standby_pkg::RST_LEAVE_CYC - 1))
                  in_reset_reg <= 1'b0;
               else rel_cnt_reg <= rel_cnt_reg + 4'd1;
            end else rel_cnt_reg <= 4'd0;
         end
         // Runaway wins over a release in the same cycle
         if (wdh_uf_reg) in_reset_reg <= 1'b1;
      end
   end

   // ==========================================
   // Control, wake enables, prescaler 12 and timer 1
   // Block reset and the reset state both clear control; RAM is outside and untouched
   wire in_rst = (state_reg == RESET_S);
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I || in_rst) begin
         ctrl_reg     <= standby_pkg::CTRL_RESET;
         wake_en_reg  <= standby_pkg::WAKE_RESET;
         pre12_reg    <= standby_pkg::PRE12_AUTO;
         pre12_ld_reg <= standby_pkg::PRE12_AUTO;
         tmr1_reg     <= standby_pkg::TMR1_AUTO;
      end else begin
         if (wr_ctrl)
            ctrl_reg <= HWDATA_I[5:0] |
               {3'b000, stop_dis, 2'b00};
         if (wr_wake) wake_en_reg <= HWDATA_I[7:0];
         if (state_reg == RUN_S && stop_cmd && !stab_sel) begin
            pre12_reg    <= standby_pkg::PRE12_AUTO;
            pre12_ld_reg <= standby_pkg::PRE12_AUTO;
            tmr1_reg     <= standby_pkg::TMR1_AUTO;
         end else if (state_reg == STAB_S && osc_tick) begin
            // Settling counted from whatever was loaded
            // Prescaler reloads from its latch, so a software period
            // repeats for every timer 1 step
            if (pre12_reg != 8'h00) pre12_reg <= pre12_reg - 8'd1;
            else if (tmr1_reg != 8'h00) begin
               pre12_reg <= pre12_ld_reg;
               tmr1_reg  <= tmr1_reg - 8'd1;
            end
         end else begin
            if (wr_pre) pre12_reg    <= HWDATA_I[7:0];
            if (wr_pre) pre12_ld_reg <= HWDATA_I[7:0];
            if (wr_tmr) tmr1_reg     <= HWDATA_I[7:0];
         end
      end
   end

   // ==========================================
   // Watchdog: low stage feeds the high stage; stopped in stop, held reloaded in the reset state
   wire wd_run  = (state_reg == RUN_S) | (state_reg == STAB_S);
   wire wd_kick = wr_wdog & ~HWDATA_I[standby_pkg::WDOG_KICK6_BIT] &
                  ~HWDATA_I[standby_pkg::WDOG_KICK7_BIT];
   wire wdl_uf  = wd_run & osc_tick & (wdl_reg == 8'h00);
   wire wdh_src = ctrl_reg[standby_pkg::CTRL_WSEL_BIT] ? wdl_uf
                                                       : (wd_run & osc_tick);
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I || in_rst) begin
         wdl_reg    <= standby_pkg::WDL_RESET;
         wdh_reg    <= standby_pkg::WDH_RESET;
         wdh_uf_reg <= 1'b0;
      end else begin
         if (wd_kick) begin
            wdl_reg <= standby_pkg::WDL_RESET;
            wdh_reg <= standby_pkg::WDH_RESET;
         end else begin
            if (wd_run && osc_tick) wdl_reg <= wdl_reg - 8'd1;
            if (wdh_src) wdh_reg <= wdh_reg - 8'd1;
         end
         // A kick in the underflow cycle is too late: the set wins
         wdh_uf_reg <= wdh_src & (wdh_reg == 8'h00);
      end
   end

   // ==========================================
   // Registered outputs
   // Taken from the next state so the oscillator and run enables
   // drop on the same edge as the stop flag rises
   wire stop_like = (state_next == STOP_S);
   always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I) begin
         HRDATA_O       <= 32'h0000_0000;
         HREADYOUT_O    <= 1'b1;
         HRESP_O        <= 1'b0;
         MAIN_OSC_RUN_O <= 1'b1;
         SUB_OSC_RUN_O  <= 1'b1;
         CPU_CLK_EN_O   <= 1'b0;
         PERIPH_RUN_O   <= 1'b0;
         TIMER_XY_RUN_O <= 1'b0;
         SERIAL_RUN_O   <= 1'b0;
         PORT_HOLD_O    <= 1'b0;
         PORT_INPUT_O   <= 1'b1;
         CORE_RESET_N_O <= 1'b0;
         STOPPED_O      <= 1'b0;
      end else begin
         HRDATA_O       <= (addr_ph & ~HWRITE_I) ? rd_mux : rdata_reg;
         HREADYOUT_O    <= 1'b1;
         HRESP_O        <= 1'b0;
         MAIN_OSC_RUN_O <= ~stop_like;
         SUB_OSC_RUN_O  <= ~stop_like & ~in_rst;
         CPU_CLK_EN_O   <= (state_next == RUN_S);
         PERIPH_RUN_O   <= (state_next == RUN_S);
         TIMER_XY_RUN_O <= ~stop_like |
                           ctrl_reg[standby_pkg::CTRL_TXY_BIT];
         SERIAL_RUN_O   <= ~stop_like |
                           ctrl_reg[standby_pkg::CTRL_SER_BIT];
         PORT_HOLD_O    <= (state_next == STOP_S) |
                           (state_next == STAB_S);
         PORT_INPUT_O   <= (state_next == RESET_S);
         CORE_RESET_N_O <= (state_next != RESET_S);
         STOPPED_O      <= (state_next == STOP_S);
      end
   end
endmodule

// File: standby_checker.sv
`timescale 1ns/1ps
// ==========================================
// Port checks for stop and reset sequencing
module standby_checker (
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic STOP_INSTRUCTION_I,
   input wire logic RESET_PIN_N_I,
   input wire logic MAIN_OSC_RUN_O,
   input wire logic SUB_OSC_RUN_O,
   input wire logic CPU_CLK_EN_O,
   input wire logic PERIPH_RUN_O,
   input wire logic PORT_HOLD_O,
   input wire logic PORT_INPUT_O,
   input wire logic CORE_RESET_N_O,
   input wire logic STOPPED_O
);
   logic [7:0] low_reg, low_next, high_reg, high_next;
   logic       seen_reg, seen_next;
   // Saturating run lengths of each pin level; stop history excludes
   // the settling wait from the plain reset timing
   assign low_next  = RESET_PIN_N_I ? 8'h00 : low_reg + 8'(low_reg != 8'hFF);
   assign high_next = RESET_PIN_N_I ? high_reg + 8'(high_reg != 8'hFF) : 8'h00;
   assign seen_next = STOPPED_O | (seen_reg & !RESET_PIN_N_I);
   always_ff @(posedge REF_CLK_I) begin
      low_reg  <= RESETN_I ? low_next : 8'h00;
      high_reg <= RESETN_I ? high_next : 8'h00;
      seen_reg <= RESETN_I & seen_next;
   end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);
   sequence stop_entered;
      $rose(STOPPED_O);
   endsequence
   sequence stop_left;
      $fell(STOPPED_O);
   endsequence
   sequence pin_released;
      $rose(CORE_RESET_N_O) && high_reg < 8'd200;
   endsequence
   AST_BUS_OKAY:
      assert property (HREADYOUT_O && !HRESP_O) else $error("bus not okay");
   AST_STOP_OSC:
      assert property (STOPPED_O |-> !MAIN_OSC_RUN_O && !SUB_OSC_RUN_O)
      else $error("oscillator runs in stop");
   AST_STOP_CLK:
      assert property (STOPPED_O |-> !CPU_CLK_EN_O) else $error("cpu clock on");
   AST_STOP_ENTRY:
      assert property (stop_entered |-> $past(STOP_INSTRUCTION_I))
      else $error("stop without instruction");
   AST_STOP_PERIPH:
      assert property (STOPPED_O |-> !PERIPH_RUN_O && PORT_HOLD_O)
      else $error("peripherals or ports not frozen");
   AST_WAKE_OSC:
      assert property (stop_left |-> ##[0:2] MAIN_OSC_RUN_O)
      else $error("main oscillator not restarted");
   AST_RST_PORTS:
      assert property (!CORE_RESET_N_O |-> PORT_INPUT_O)
      else $error("ports not input in reset");
   AST_RST_ENTER:
      assert property (low_reg == 8'd50 && !seen_reg |-> !CORE_RESET_N_O)
      else $error("reset state not entered");
   AST_RST_EARLY:
      assert property ($fell(CORE_RESET_N_O) && !RESET_PIN_N_I
                       |-> low_reg >= 8'd38) else $error("reset too early");
   AST_RST_LEAVE:
      assert property (pin_released |-> high_reg inside {[8'd21:8'd40]})
      else $error("reset release time off");
endmodule
bind stop_mode_standby_control standby_checker chk (.REF_CLK_I, .RESETN_I,
   .HREADYOUT_O, .HRESP_O, .STOP_INSTRUCTION_I, .RESET_PIN_N_I,
   .MAIN_OSC_RUN_O, .SUB_OSC_RUN_O, .CPU_CLK_EN_O, .PERIPH_RUN_O,
   .PORT_HOLD_O, .PORT_INPUT_O, .CORE_RESET_N_O, .STOPPED_O);

// File: standby_partner.sv
`timescale 1ns/1ps
// ==========================================
// Core, reset pin source and wake sources
module standby_partner (
   input  wire logic       clk_i,
   input  wire logic       stopped_i,
   output logic            stop_instr_o,
   output logic            pin_n_o,
   output logic [7:0]      wake_o
);
   // Idle: no stop, pin released, sources low
   initial begin
      stop_instr_o = 1'b0;
      pin_n_o = 1'b1;
      wake_o = 8'h00;
   end
   // Stop held until seen taken, at most 8 edges
   task automatic do_stop(output logic ok);
      ok = 1'b0;
      @(posedge clk_i);
      stop_instr_o <= 1'b1;
      for (int k = 0; k < 8 && !ok; k++) begin
         @(posedge clk_i);
         ok = (stopped_i === 1'b1);
      end
      stop_instr_o <= 1'b0;
   endtask
   // Pulse long enough to pass the synchroniser
   task automatic wake(input int i);
      @(posedge clk_i);
      wake_o[i] <= 1'b1;
      repeat (4) @(posedge clk_i);
      wake_o[i] <= 1'b0;
   endtask
   // Long holds cover oscillator settling after stop
   task automatic pin_low(input int n);
      @(posedge clk_i);
      pin_n_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      pin_n_o <= 1'b1;
   endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench
module tb;
   localparam logic [7:0] CTRL = standby_pkg::CTRL_OFS;
   localparam logic [7:0] WAKE = standby_pkg::WAKE_OFS;
   localparam logic [7:0] WDOG = standby_pkg::WDOG_OFS;
   logic        clk = 1'b0;
   logic        rstn, hwrite, hsel, hready, hresp, stop_i, pin_n, mosc;
   logic        sosc, cpuclk, periph, txy, ser, hold, pin_in, core_rn;
   logic        stopped, ok, md;
   logic [31:0] haddr, hwdata, hrdata, v, w;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  wake;
   int          bad_count, checked, n, mdl[int];
   always #12.5 clk = ~clk;
   stop_mode_standby_control dut (.REF_CLK_I(clk), .RESETN_I(rstn),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
      .HWDATA_I(hwdata), .HSEL_I(hsel), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .STOP_INSTRUCTION_I(stop_i),
      .RESET_PIN_N_I(pin_n), .EXTERNAL_IRQ_PINS_I(wake[3:0]),
      .COUNTER_PIN_ZERO_I(wake[4]), .COUNTER_PIN_ONE_I(wake[5]),
      .SERIAL_IRQ_I(wake[6]), .TIMER_XY_IRQ_I(wake[7]), .MAIN_OSC_RUN_O(mosc),
      .SUB_OSC_RUN_O(sosc), .CPU_CLK_EN_O(cpuclk), .PERIPH_RUN_O(periph),
      .TIMER_XY_RUN_O(txy), .SERIAL_RUN_O(ser), .PORT_HOLD_O(hold),
      .PORT_INPUT_O(pin_in), .CORE_RESET_N_O(core_rn), .STOPPED_O(stopped));
   standby_partner p (.clk_i(clk), .stopped_i(stopped), .stop_instr_o(stop_i),
      .pin_n_o(pin_n), .wake_o(wake));
   // ==========================================
   // Reporting and waits
   task conclude();
      $display("Counts: %0d checks, %0d mismatches", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task chk1(input string nm, input logic got, input logic exp);
      chk(nm, {31'h0, got}, {31'h0, exp});
   endtask
   // Bounded wait; n holds the edges taken
   task automatic hop(ref logic s, input logic lvl, input int lim);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (s !== lvl && n < lim);
      if (s !== lvl) begin
         chk("wait limit", 32'h0000_0001, 32'h0000_0000);
         conclude();
      end
   endtask
   // ==========================================
   // Bus master and register model
   task automatic bus(input logic wen, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wen;
      hop(hready, 1'b1, 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      hop(hready, 1'b1, 50);
      v = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      // Stop-disable bit is sticky once set
      if (a == CTRL) mdl[a] = (d & 32'h0000_003E) | (mdl[a] & 32'h0000_0004);
      if (a == WAKE) mdl[a] = d & 32'h0000_00FF;
   endtask
   task automatic rdc(input logic [7:0] a);
      bus(1'b0, a, 32'h0000_0000);
      chk("register", v, mdl.exists(a) ? 32'(mdl[a]) : 32'h0000_0000);
   endtask
   // Stop, stray source ignored, enabled source wakes, settling timed
   task automatic nap(input int src, input logic m, input int lo, input int hi);
      p.do_stop(ok);
      chk1("stop taken", ok, 1'b1);
      @(posedge clk);
      chk1("main osc", mosc, 1'b0);
      chk1("sub osc", sosc, 1'b0);
      chk1("cpu clock", cpuclk, 1'b0);
      chk1("periph", periph, 1'b0);
      chk1("timer xy", txy, m);
      chk1("serial", ser, m);
      chk1("port hold", hold, 1'b1);
      p.wake((src + 1) % 8);
      // Serial and timer sources must not wake outside external mode
      if (!m) begin
         p.wake(6);
         p.wake(7);
      end
      repeat (10) @(posedge clk);
      chk1("stray source", stopped, 1'b1);
      p.wake(src);
      hop(stopped, 1'b0, 20);
      hop(cpuclk, 1'b1, 3000);
      chk1("settle time", n >= lo && n <= hi, 1'b1);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      rstn = 1'b0;
      {hwrite, hsel, htrans, hsize} = 7'h02;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      void'($urandom(63054));
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      hop(core_rn, 1'b1, 100);
      chk1("release time", n >= 21 && n <= 40, 1'b1);
      rdc(CTRL);
      rdc(WAKE);
      wr(8'h20, $urandom());
      rdc(8'h20);
      chk1("hresp", hresp, 1'b0);
      $display("Test registers done");
      for (int i = 0; i < 8; i++) begin
         md = i[0] || i >= 6;
         wr(CTRL, {26'h0, md, md, 4'h8});
         wr(WAKE, 32'h0000_0001 << i);
         wr(WDOG, 32'h0000_0000);
         nap(i, md, 500, 3000);
      end
      $display("Test wake sources done");
      wr(standby_pkg::PRE12_OFS, $urandom_range(3, 1));
      wr(standby_pkg::TMR1_OFS, 32'h0000_0000);
      wr(CTRL, 32'h0000_000A);
      wr(WAKE, 32'h0000_00C1);
      nap(0, 1'b0, 1, 100);
      wr(CTRL, 32'h0000_000C);
      wr(CTRL, 32'h0000_0008);
      rdc(CTRL);
      p.do_stop(ok);
      chk1("stop refused", ok, 1'b0);
      $display("Test settle and disable done");
      p.pin_low(30);
      chk1("short pin low", core_rn, 1'b1);
      p.pin_low(60);
      chk1("long pin low", core_rn, 1'b0);
      hop(core_rn, 1'b1, 100);
      chk1("pin release time", n >= 21 && n <= 40, 1'b1);
      mdl.delete();
      rdc(CTRL);
      wr(CTRL, 32'h0000_0008);
      p.do_stop(ok);
      p.pin_low(200);
      chk1("stop left", stopped, 1'b0);
      chk1("osc restart", mosc, 1'b1);
      chk1("ports input", pin_in, 1'b1);
      hop(core_rn, 1'b1, 100);
      mdl.delete();
      $display("Test reset pin done");
      wr(CTRL, 32'h0000_0008);
      wr(WDOG, 32'h0000_0000);
      bus(1'b0, WDOG, 32'h0000_0000);
      w = v;
      chk1("kick reload", w[15:8] === 8'hFF && w[7:0] >= 8'hF0, 1'b1);
      repeat (600) @(posedge clk);
      bus(1'b0, WDOG, 32'h0000_0000);
      chk1("watchdog counts", v[15:0] < w[15:0], 1'b1);
      // Per-tick high stage: 256 ticks of two clocks to underflow
      wr(WDOG, 32'h0000_0000);
      wr(CTRL, 32'h0000_0000);
      hop(core_rn, 1'b0, 700);
      chk1("runaway reset", n >= 500 && n <= 530, 1'b1);
      $display("Test watchdog done");
      conclude();
   end
endmodule
